// ==== pmc_clk_div.sv ====
`timescale 1ns/1ns
`default_nettype none
module pmc_clk_div
  import pmc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  pmc_div_if.div    div_bus
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } pmc_div_state_type;

  pmc_div_state_type div_reg;
  pmc_div_state_type div_next;

  // count source edges, one tick per full ratio period
  always_comb begin
    div_next      = div_reg;
    div_next.tick = 1'b0;
    if (div_bus.restart) begin
      div_next.cnt = 5'h00;
    end else if (div_bus.src_tick) begin
      if ((div_reg.cnt + 5'h01) >= div_bus.ratio) begin
        div_next.cnt  = 5'h00;
        div_next.tick = 1'b1;
      end else begin
        div_next.cnt = div_reg.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '{cnt: 5'h00, tick: 1'b0};
    end else if (clk_en) begin
      div_reg <= div_next;
    end
  end

  assign div_bus.cpu_tick = div_reg.tick;

endmodule
`default_nettype wire

// ==== pmc_div_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface pmc_div_if;
  logic [4:0] ratio;
  logic       src_tick;
  logic       restart;
  logic       cpu_tick;

  modport ctrl (output ratio, output src_tick, output restart, input cpu_tick);
  modport div  (input ratio, input src_tick, input restart, output cpu_tick);
endinterface
`default_nettype wire

// ==== pmc_pkg.sv ====
`default_nettype none
package pmc_pkg;

  // register byte offsets
  localparam logic [7:0] CLOCK_CONTROL0_OFS        = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL1_OFS        = 8'h04;
  localparam logic [7:0] CLOCK_CONTROL3_OFS        = 8'h08;
  localparam logic [7:0] OSC_CONTROL_OFS           = 8'h0c;
  localparam logic [7:0] PROTECT_REGISTER_OFS      = 8'h10;
  localparam logic [7:0] POWER_STATUS_OFS          = 8'h14;
  localparam logic [7:0] VOLTAGE_POWER_CONTROL_OFS = 8'h34;

  // clock_control0 fields
  localparam int CC0_WAIT_CLK_STOP_LO_BIT = 1;
  localparam int CC0_WAIT_CLK_STOP_HI_BIT = 2;
  localparam int CC0_CRYSTAL_STOP_BIT     = 5;
  localparam int CC0_CPU_DIV8_SEL_BIT     = 6;
  // clock_control1 fields
  localparam int CC1_ALL_CLOCK_STOP_BIT   = 0;
  localparam int CC1_CRYSTAL_PIN_SEL_BIT  = 3;
  localparam int CC1_LOWSPEED_OSC_STOP_BIT = 4;
  localparam int CC1_CPU_DIV_LO_BIT       = 6;
  localparam int CC1_CPU_DIV_HI_BIT       = 7;
  // clock_control3 fields
  localparam int CC3_WAIT_CONTROL_BIT     = 0;
  localparam int CC3_WAKE_NO_DIVIDE_BIT   = 5;
  localparam int CC3_WAKE_CLOCK_SEL_LO_BIT = 6;
  localparam int CC3_WAKE_CLOCK_SEL_HI_BIT = 7;
  // osc_control fields
  localparam int OSC_STOP_IRQ_EN_BIT      = 1;
  localparam int OSC_ONCHIP_CLOCK_SEL_BIT = 2;
  // protect_register fields
  localparam int PROT_CLOCK_WRITE_EN_BIT  = 0;
  localparam int PROT_VOLTAGE_REG_WRITE_EN_BIT = 3;
  // voltage_power_control fields
  localparam int VPC_LOW_POWER_INTERNAL_EN_BIT = 0;
  localparam int VPC_DETECT0_EN_BIT       = 5;
  localparam int VPC_DETECT1_EN_BIT       = 6;
  localparam int VPC_DETECT2_EN_BIT       = 7;
  // power_status fields
  localparam int STAT_IN_WAIT_BIT         = 0;
  localparam int STAT_DETECT1_ACTIVE_BIT  = 1;
  localparam int STAT_DETECT2_ACTIVE_BIT  = 2;
  localparam int STAT_ONCHIP_SOURCE_BIT   = 3;
  localparam int STAT_RATIO_LO_BIT        = 4;
  localparam int STAT_RATIO_HI_BIT        = 8;

  // writable bit masks
  localparam logic [7:0] CC0_MASK  = 8'h66;
  localparam logic [7:0] CC1_MASK  = 8'hd9;
  localparam logic [7:0] CC3_MASK  = 8'he1;
  localparam logic [7:0] OSC_MASK  = 8'h06;
  localparam logic [7:0] PROT_MASK = 8'h09;
  localparam logic [7:0] VPC_MASK  = 8'he1;

  // reset values
  localparam logic [7:0] CC0_RESET  = 8'h00;
  localparam logic [7:0] CC1_RESET  = 8'h00;
  localparam logic [7:0] CC3_RESET  = 8'h00;
  localparam logic [7:0] OSC_RESET  = 8'h04;
  localparam logic [7:0] PROT_RESET = 8'h00;
  localparam logic [7:0] VPC_RESET  = 8'h00;

  // encodings
  localparam logic [1:0] WAIT_STOP_NONE     = 2'h0;
  localparam logic [1:0] WAKE_SEL_PREVIOUS  = 2'h0;
  localparam logic [1:0] WAKE_SEL_CRYSTAL   = 2'h3;
  localparam logic [1:0] STRAP_SETTLE_COUNT = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS          = 4;
  localparam int ENABLE_TO_ACTIVE_NS    = 100000;
  localparam int DET_CNT_W              = 20;
  localparam int DETECT_DELAY_DEFAULT   = (ENABLE_TO_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {PMC_RUN, PMC_WAIT, PMC_RESUME} pmc_mode_type;

  // source ticks per processor clock tick
  function automatic logic [4:0] pmc_div_ratio(input logic div8, input logic [1:0] div_code);
    logic [4:0] r;
    r = 5'h01;
    if (div8) begin
      r = 5'h08;
    end else begin
      case (div_code)
        2'h0:    r = 5'h01;
        2'h1:    r = 5'h02;
        2'h2:    r = 5'h04;
        default: r = 5'h10;
      endcase
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// ==== pmc_top.sv ====
// Operation
// - vpc bit 0 enables internal low power
// - vpc bits 5..7 enable detectors 0..2
// - detectors 1/2 active after enable delay
// - divider: 1,2,4,16 by field, div8 overrides
// - onchip select uses low-speed oscillator as source
// - oscillator ticks kept while not stopped
// - wait stops processor and unprotected watchdog
// - wait stop field gates peripheral clocks
// - wait entered by instruction or control write
// - osc-stop irq enable keeps processor clock
// - ports hold their state during wait
// - wait ends on reset or peripheral interrupt; with peripheral clocks gated, only the async interrupt ends it
// - gated peripherals cannot wake the device
// - interrupt wake clears wait control bit
// - wait entry applies no-divide setting, wake applies wake clock
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pmc_top
  import pmc_pkg::*;
#(
  parameter logic [DET_CNT_W-1:0] DETECT_DELAY_CYCLES = DET_CNT_W'(DETECT_DELAY_DEFAULT)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        crystal_clk_in,
  input  wire logic        lowspeed_osc_in,
  input  wire logic        startup_detect_option,
  input  wire logic        detect1_level,
  input  wire logic        detect2_level,
  input  wire logic        periph_irq,
  input  wire logic        async_irq,
  input  wire logic        wait_instr,
  input  wire logic        wdt_protect,
  output logic             cpu_clk_en,
  output logic             wdt_clk_en,
  output logic             periph_clk_en,
  output logic             onchip_osc_clock,
  output logic             detect_sample_clock,
  output logic             low_power_internal_en,
  output logic      [2:0]  detect_en,
  output logic             detect1_active,
  output logic             detect2_active,
  output logic             detect1_flag,
  output logic             detect2_flag,
  output logic             io_hold,
  output logic             in_wait,
  output logic             all_clock_stop,
  output logic             crystal_stop,
  output logic             crystal_pin_sel,
  output logic             onchip_clock_select
);

  typedef struct packed {
    pmc_mode_type           mode;
    logic [7:0]             cc0;
    logic [7:0]             cc1;
    logic [7:0]             cc3;
    logic [7:0]             osc;
    logic [7:0]             prot;
    logic [7:0]             vpc;
    logic [2:0]             xtal_sync;
    logic [2:0]             lso_sync;
    logic [1:0]             strap_sync;
    logic [1:0]             pirq_sync;
    logic [1:0]             airq_sync;
    logic [1:0]             det1_sync;
    logic [1:0]             det2_sync;
    logic [1:0]             strap_wait;
    logic                   strap_done;
    logic [DET_CNT_W-1:0]   det1_cnt;
    logic [DET_CNT_W-1:0]   det2_cnt;
    logic [31:0]            rdata;
    logic                   rerr;
    logic                   cpu_en;
    logic                   wdt_en;
    logic                   src_tick;
    logic                   osc_tick;
  } pmc_state_type;

  localparam pmc_state_type PMC_STATE_RESET = '{
    mode: PMC_RUN, cc0: CC0_RESET, cc1: CC1_RESET, cc3: CC3_RESET, osc: OSC_RESET,
    prot: PROT_RESET, vpc: VPC_RESET, default: '0};

  pmc_state_type st_reg;
  pmc_state_type st_next;

  pmc_div_if div_bus ();

  logic       hit_cc0;
  logic       hit_cc1;
  logic       hit_cc3;
  logic       hit_osc;
  logic       hit_prot;
  logic       hit_stat;
  logic       hit_vpc;
  logic       addr_ok;
  logic       wr_en;
  logic       clk_we;
  logic       volt_we;
  logic       xtal_rise;
  logic       lso_rise;
  logic       wake_req;
  logic       cpu_run;
  logic [1:0] wait_stop;
  logic [4:0] ratio;
  logic [7:0] rd_byte;

  // next detector delay count, restarts whenever enable drops
  function automatic logic [DET_CNT_W-1:0] det_count(input logic en, input logic [DET_CNT_W-1:0] cnt);
    logic [DET_CNT_W-1:0] r;
    r = cnt;
    if (!en) begin
      r = '0;
    end else if (cnt != DETECT_DELAY_CYCLES) begin
      r = cnt + DET_CNT_W'(1);
    end
    return r;
  endfunction

  // address decode and bus qualifiers
  assign hit_cc0  = (paddr == CLOCK_CONTROL0_OFS);
  assign hit_cc1  = (paddr == CLOCK_CONTROL1_OFS);
  assign hit_cc3  = (paddr == CLOCK_CONTROL3_OFS);
  assign hit_osc  = (paddr == OSC_CONTROL_OFS);
  assign hit_prot = (paddr == PROTECT_REGISTER_OFS);
  assign hit_stat = (paddr == POWER_STATUS_OFS);
  assign hit_vpc  = (paddr == VOLTAGE_POWER_CONTROL_OFS);
  assign addr_ok  = hit_cc0 | hit_cc1 | hit_cc3 | hit_osc | hit_prot | hit_stat | hit_vpc;
  assign wr_en    = psel & penable & pwrite;
  assign clk_we   = st_reg.prot[PROT_CLOCK_WRITE_EN_BIT];
  // voltage register guarded by write enable
  assign volt_we  = st_reg.prot[PROT_VOLTAGE_REG_WRITE_EN_BIT];

  // edge detect on second and third stages only
  assign xtal_rise = st_reg.xtal_sync[1] & ~st_reg.xtal_sync[2];
  assign lso_rise  = st_reg.lso_sync[1] & ~st_reg.lso_sync[2];
  assign wait_stop = st_reg.cc0[CC0_WAIT_CLK_STOP_HI_BIT:CC0_WAIT_CLK_STOP_LO_BIT];
  // ratio from div8 and two-bit field
  assign ratio = pmc_div_ratio(st_reg.cc0[CC0_CPU_DIV8_SEL_BIT],
                               st_reg.cc1[CC1_CPU_DIV_HI_BIT:CC1_CPU_DIV_LO_BIT]);

  // gated mode: only async sources wake
  assign wake_req = (wait_stop == WAIT_STOP_NONE) ? st_reg.pirq_sync[1] : st_reg.airq_sync[1];
  // processor clock kept with osc-stop irq enabled
  assign cpu_run  = (st_reg.mode != PMC_WAIT) | st_reg.osc[OSC_STOP_IRQ_EN_BIT];

  // divider hookup
  assign div_bus.ratio    = ratio;
  assign div_bus.src_tick = st_reg.src_tick;
  assign div_bus.restart  = (st_reg.mode == PMC_WAIT) & wake_req;

  pmc_clk_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .div_bus (div_bus)
  );

  // read data select
  always_comb begin
    rd_byte = 8'h00;
    if (hit_cc0) begin
      rd_byte = st_reg.cc0;
    end else if (hit_cc1) begin
      rd_byte = st_reg.cc1;
    end else if (hit_cc3) begin
      rd_byte = st_reg.cc3;
    end else if (hit_osc) begin
      rd_byte = st_reg.osc;
    end else if (hit_prot) begin
      rd_byte = st_reg.prot;
    end else if (hit_vpc) begin
      rd_byte = st_reg.vpc;
    end
  end

  // next state
  always_comb begin
    st_next = st_reg;
    // synchronisers, first stage feeds second only
    st_next.xtal_sync  = {st_reg.xtal_sync[1:0], crystal_clk_in};
    st_next.lso_sync   = {st_reg.lso_sync[1:0], lowspeed_osc_in};
    st_next.strap_sync = {st_reg.strap_sync[0], startup_detect_option};
    st_next.pirq_sync  = {st_reg.pirq_sync[0], periph_irq};
    st_next.airq_sync  = {st_reg.airq_sync[0], async_irq};
    st_next.det1_sync  = {st_reg.det1_sync[0], detect1_level};
    st_next.det2_sync  = {st_reg.det2_sync[0], detect2_level};

    // read data latched in the setup cycle
    if (psel && !penable) begin
      st_next.rerr  = ~addr_ok;
      st_next.rdata = {24'h000000, rd_byte};
      if (hit_stat) begin
        st_next.rdata[STAT_IN_WAIT_BIT]        = (st_reg.mode != PMC_RUN);
        st_next.rdata[STAT_DETECT1_ACTIVE_BIT] = detect1_active;
        st_next.rdata[STAT_DETECT2_ACTIVE_BIT] = detect2_active;
        st_next.rdata[STAT_ONCHIP_SOURCE_BIT]  = st_reg.osc[OSC_ONCHIP_CLOCK_SEL_BIT];
        st_next.rdata[STAT_RATIO_HI_BIT:STAT_RATIO_LO_BIT] = ratio;
      end
    end

    // register writes
    if (wr_en && hit_prot) begin
      st_next.prot = pwdata[7:0] & PROT_MASK;
    end
    if (wr_en && clk_we && hit_cc0) begin
      st_next.cc0 = pwdata[7:0] & CC0_MASK;
    end
    if (wr_en && clk_we && hit_cc1) begin
      st_next.cc1 = pwdata[7:0] & CC1_MASK;
    end
    if (wr_en && clk_we && hit_cc3) begin
      st_next.cc3 = pwdata[7:0] & CC3_MASK;
    end
    if (wr_en && clk_we && hit_osc) begin
      st_next.osc = pwdata[7:0] & OSC_MASK;
    end
    if (wr_en && volt_we && hit_vpc) begin
      st_next.vpc = pwdata[7:0] & VPC_MASK;
    end

    // detector 0 default caught from strap after release
    if (!st_reg.strap_done) begin
      if (st_reg.strap_wait == STRAP_SETTLE_COUNT) begin
        st_next.strap_done = 1'b1;
        st_next.vpc[VPC_DETECT0_EN_BIT] = ~st_reg.strap_sync[1];
      end else begin
        st_next.strap_wait = st_reg.strap_wait + 2'h1;
      end
    end

    // power mode sequencing
    case (st_reg.mode)
      PMC_RUN: begin
        // entry by instruction or control write
        if (wait_instr || (wr_en && clk_we && hit_cc3 && pwdata[CC3_WAIT_CONTROL_BIT])) begin
          st_next.mode = PMC_WAIT;
          if (st_next.cc3[CC3_WAKE_NO_DIVIDE_BIT]) begin
            st_next.cc0[CC0_CPU_DIV8_SEL_BIT] = 1'b0;
            st_next.cc1[CC1_CPU_DIV_HI_BIT:CC1_CPU_DIV_LO_BIT] = 2'h0;
          end
        end
      end
      PMC_WAIT: begin
        if (wake_req) begin
          st_next.mode = PMC_RESUME;
          // wake clears wait control, a write wins
          if (!(wr_en && clk_we && hit_cc3 && pwdata[CC3_WAIT_CONTROL_BIT])) begin
            st_next.cc3[CC3_WAIT_CONTROL_BIT] = 1'b0;
          end
          if (st_reg.cc3[CC3_WAKE_CLOCK_SEL_HI_BIT:CC3_WAKE_CLOCK_SEL_LO_BIT] == WAKE_SEL_CRYSTAL) begin
            st_next.cc0[CC0_CRYSTAL_STOP_BIT]         = 1'b0;
            st_next.cc1[CC1_CRYSTAL_PIN_SEL_BIT]      = 1'b1;
            st_next.osc[OSC_ONCHIP_CLOCK_SEL_BIT]     = 1'b0;
          end
        end
      end
      PMC_RESUME: begin
        // processor released on first divided edge
        if (div_bus.cpu_tick) begin
          st_next.mode = PMC_RUN;
        end
      end
      default: begin
        st_next.mode = PMC_RUN;
      end
    endcase

    // onchip select keeps low-speed oscillator on
    if (st_next.osc[OSC_ONCHIP_CLOCK_SEL_BIT]) begin
      st_next.cc1[CC1_LOWSPEED_OSC_STOP_BIT] = 1'b0;
    end

    // source edge: oscillator or running crystal
    st_next.src_tick = st_reg.osc[OSC_ONCHIP_CLOCK_SEL_BIT] ?
                       (lso_rise & ~st_reg.cc1[CC1_LOWSPEED_OSC_STOP_BIT]) :
                       (xtal_rise & ~st_reg.cc0[CC0_CRYSTAL_STOP_BIT]);
    st_next.osc_tick = lso_rise & ~st_reg.cc1[CC1_LOWSPEED_OSC_STOP_BIT];
    // processor and unprotected watchdog gated in wait unless osc-stop irq enabled
    st_next.cpu_en   = div_bus.cpu_tick & cpu_run;
    st_next.wdt_en   = div_bus.cpu_tick & (cpu_run | wdt_protect);

    st_next.det1_cnt = det_count(st_reg.vpc[VPC_DETECT1_EN_BIT], st_reg.det1_cnt);
    st_next.det2_cnt = det_count(st_reg.vpc[VPC_DETECT2_EN_BIT], st_reg.det2_cnt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= PMC_STATE_RESET;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // bus answers, zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel & penable & st_reg.rerr;
  assign prdata  = st_reg.rdata;

  // clock enables
  assign cpu_clk_en          = st_reg.cpu_en;
  assign wdt_clk_en          = st_reg.wdt_en;
  // peripheral clocks gated by wait stop field
  assign periph_clk_en       = ~((st_reg.mode == PMC_WAIT) & (wait_stop != WAIT_STOP_NONE));
  assign onchip_osc_clock    = st_reg.osc_tick;
  assign detect_sample_clock = st_reg.osc_tick;

  // power and detector outputs
  assign low_power_internal_en = st_reg.vpc[VPC_LOW_POWER_INTERNAL_EN_BIT];
  assign detect_en      = {st_reg.vpc[VPC_DETECT2_EN_BIT], st_reg.vpc[VPC_DETECT1_EN_BIT],
                           st_reg.vpc[VPC_DETECT0_EN_BIT]};
  assign detect1_active = st_reg.vpc[VPC_DETECT1_EN_BIT] & (st_reg.det1_cnt == DETECT_DELAY_CYCLES);
  assign detect2_active = st_reg.vpc[VPC_DETECT2_EN_BIT] & (st_reg.det2_cnt == DETECT_DELAY_CYCLES);
  assign detect1_flag   = detect1_active & st_reg.det1_sync[1];
  assign detect2_flag   = detect2_active & st_reg.det2_sync[1];

  // mode outputs
  // port state held while waiting
  assign io_hold             = (st_reg.mode == PMC_WAIT);
  assign in_wait             = (st_reg.mode != PMC_RUN);
  assign all_clock_stop      = st_reg.cc1[CC1_ALL_CLOCK_STOP_BIT];
  assign crystal_stop        = st_reg.cc0[CC0_CRYSTAL_STOP_BIT];
  assign crystal_pin_sel     = st_reg.cc1[CC1_CRYSTAL_PIN_SEL_BIT];
  assign onchip_clock_select = st_reg.osc[OSC_ONCHIP_CLOCK_SEL_BIT];

endmodule
`default_nettype wire

// ==== pmc_top_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module pmc_props
  import pmc_pkg::*;
#(
  parameter logic [DET_CNT_W-1:0] DETECT_DELAY_CYCLES = 8
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       wait_instr,
  input wire logic       periph_irq,
  input wire logic       async_irq,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       onchip_osc_clock,
  input wire logic       detect_sample_clock,
  input wire logic       low_power_internal_en,
  input wire logic [2:0] detect_en,
  input wire logic       detect1_active,
  input wire logic       detect1_flag,
  input wire logic       io_hold,
  input wire logic       in_wait
);
  logic [DET_CNT_W-1:0] det_cnt_reg;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // cycles detector 1 has stayed enabled, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_cnt_reg <= '0;
    end else if (!detect_en[1]) begin
      det_cnt_reg <= '0;
    end else if (det_cnt_reg != DETECT_DELAY_CYCLES) begin
      det_cnt_reg <= det_cnt_reg + 1'b1;
    end
  end

  chk_low_power_src: assert property ($changed(low_power_internal_en) |->
    $past(psel && penable && pwrite && paddr == VOLTAGE_POWER_CONTROL_OFS))
    else $error("low power bit moved without a register write");
  chk_detect_en_src: assert property ($changed(detect_en[2:1]) |->
    $past(psel && penable && pwrite && paddr == VOLTAGE_POWER_CONTROL_OFS))
    else $error("detector enable moved without a register write");
  chk_detect_delay: assert property ($rose(detect1_active) |->
    detect_en[1] && det_cnt_reg >= DETECT_DELAY_CYCLES - 1'b1)
    else $error("detector active before its delay");
  chk_detect_flag: assert property (detect1_flag |-> detect1_active)
    else $error("detector flag without active detector");
  chk_osc_pulse: assert property (onchip_osc_clock |-> detect_sample_clock ##1 !onchip_osc_clock)
    else $error("oscillator tick malformed");
  chk_wait_entry: assert property (wait_instr && !in_wait |=> io_hold)
    else $error("wait instruction did not enter wait");
  chk_cpu_gated: assert property (io_hold && $past(io_hold) && $past(io_hold, 2) |-> !cpu_clk_en)
    else $error("processor tick during wait");
  chk_periph_run: assert property (!io_hold |-> periph_clk_en)
    else $error("peripheral clock gated outside wait");
  chk_wake_bound: assert property (io_hold && periph_irq && async_irq |-> ##[1:6] !io_hold)
    else $error("interrupt did not end wait");
  chk_resume_tick: assert property ($fell(in_wait) |-> ##[0:1] cpu_clk_en)
    else $error("no processor tick at resume");
endmodule

bind pmc_top pmc_props #(.DETECT_DELAY_CYCLES(DETECT_DELAY_CYCLES)) u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .wait_instr, .periph_irq, .async_irq, .cpu_clk_en, .periph_clk_en, .onchip_osc_clock,
  .detect_sample_clock, .low_power_internal_en, .detect_en, .detect1_active, .detect1_flag, .io_hold, .in_wait);
`default_nettype wire

// ==== pmc_top_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module pmc_top_tb_top;
  import pmc_pkg::*;
  localparam logic [19:0] DLY = 20'h8;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, tick;
  logic [31:0] pwdata, prdata, rd;
  logic        crystal_clk_in, lowspeed_osc_in, startup_detect_option, detect1_level, detect2_level;
  logic        periph_irq, async_irq, wait_instr, wdt_protect, cpu_clk_en, wdt_clk_en, periph_clk_en;
  logic        onchip_osc_clock, detect_sample_clock, low_power_internal_en, detect1_active, detect2_active;
  logic        detect1_flag, detect2_flag, io_hold, in_wait, all_clock_stop, crystal_stop, crystal_pin_sel;
  logic        onchip_clock_select;
  logic [2:0]  detect_en;
  int          err_count, total_checks, ncpu, nwdt, c0, w0;
  logic [7:0]  ofs_tab [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h34};
  logic [7:0]  rst_tab [6] = '{CC0_RESET, CC1_RESET, CC3_RESET, OSC_RESET, PROT_RESET, 8'h20};
  logic [7:0]  d8_tab [5]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
  logic [7:0]  dv_tab [5]  = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'hc0};
  logic [4:0]  rt_tab [5]  = '{5'h01, 5'h02, 5'h04, 5'h10, 5'h08};

  pmc_top #(.DETECT_DELAY_CYCLES(DLY)) uut (.*);

  always #2 pclk = ~pclk;

  // slow source clocks and tick counters
  always @(posedge pclk) begin
    tick <= tick + 8'h01;
    crystal_clk_in <= tick[1];
    lowspeed_osc_in <= tick[2];
    ncpu <= ncpu + (cpu_clk_en === 1'b1);
    nwdt <= nwdt + (wdt_clk_en === 1'b1);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, waits for pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // no answer in time counts as a mismatch
    if (pready !== 1'b1) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic wake_wait();
    int n;
    n = 0;
    while (in_wait !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    // stuck in wait counts as a mismatch
    if (in_wait !== 1'b0) err_count++;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (25000) @(posedge pclk);
    err_count++;
    finish_test();
  end

  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, tick} = '0;
    {crystal_clk_in, lowspeed_osc_in, startup_detect_option, detect1_level, detect2_level} = '0;
    {periph_irq, async_irq, wait_instr, wdt_protect, ncpu, nwdt, err_count, total_checks} = '0;
    clk_en = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    foreach (ofs_tab[i]) rdchk(ofs_tab[i], {24'h0, rst_tab[i]});
    rdchk(POWER_STATUS_OFS, 32'h18);
    xfer(1'b0, 8'h18, 32'h0);
    check(er, 1'b1);
    xfer(1'b1, VOLTAGE_POWER_CONTROL_OFS, 32'he1);
    rdchk(VOLTAGE_POWER_CONTROL_OFS, 32'h20);
    xfer(1'b1, PROTECT_REGISTER_OFS, 32'h09);
    xfer(1'b1, VOLTAGE_POWER_CONTROL_OFS, 32'hff);
    rdchk(VOLTAGE_POWER_CONTROL_OFS, 32'he1);
    detect1_level <= 1'b1;
    check(low_power_internal_en, 1'b1);
    check(detect_en, 3'h7);
    check(detect1_active, 1'b0);
    repeat (DLY + 4) @(negedge pclk);
    check(detect1_flag, 1'b1);
    check(detect2_flag, 1'b0);
    xfer(1'b0, POWER_STATUS_OFS, 32'h0);
    check(rd[2:1], 2'h3);
    xfer(1'b1, VOLTAGE_POWER_CONTROL_OFS, 32'h20);
    @(negedge pclk);
    check(detect1_active, 1'b0);
    // divider encodings
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, CLOCK_CONTROL0_OFS, {24'h0, d8_tab[i]});
      xfer(1'b1, CLOCK_CONTROL1_OFS, {24'h0, dv_tab[i]});
      xfer(1'b0, POWER_STATUS_OFS, 32'h0);
      check(rd[8:4], rt_tab[i]);
    end
    // all-clock-stop bit reaches its output
    xfer(1'b1, CLOCK_CONTROL1_OFS, 32'h01);
    @(negedge pclk);
    check(all_clock_stop, 1'b1);
    xfer(1'b1, CLOCK_CONTROL1_OFS, 32'hc0);
    // wait by control bit, wake to crystal
    xfer(1'b1, CLOCK_CONTROL0_OFS, 32'h20);
    xfer(1'b1, CLOCK_CONTROL3_OFS, 32'he1);
    @(negedge pclk);
    check(io_hold, 1'b1);
    rdchk(CLOCK_CONTROL1_OFS, 32'h00);
    check(io_hold, 1'b1);
    periph_irq <= 1'b1;
    wake_wait();
    periph_irq <= 1'b0;
    @(negedge pclk);
    check({crystal_stop, crystal_pin_sel, onchip_clock_select}, 3'h2);
    rdchk(CLOCK_CONTROL3_OFS, 32'he0);
    // wait by instruction with peripheral clocks stopped
    xfer(1'b1, CLOCK_CONTROL0_OFS, 32'h02);
    xfer(1'b1, CLOCK_CONTROL3_OFS, 32'h00);
    wait_instr <= 1'b1;
    wdt_protect <= 1'b1;
    @(posedge pclk);
    wait_instr <= 1'b0;
    periph_irq <= 1'b1;
    @(negedge pclk);
    check(periph_clk_en, 1'b0);
    // the tick launched at the entry edge still belongs to run
    @(negedge pclk);
    c0 = ncpu;
    w0 = nwdt;
    repeat (40) @(negedge pclk);
    check(in_wait, 1'b1);
    check(ncpu - c0, 32'h0);
    check(nwdt > w0, 1'b1);
    @(posedge pclk);
    async_irq <= 1'b1;
    wake_wait();
    async_irq <= 1'b0;
    periph_irq <= 1'b0;
    @(negedge pclk);
    check({in_wait, periph_clk_en}, 2'h1);
    // second reset with the strap set: detector 0 comes up off
    startup_detect_option <= 1'b1;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rdchk(VOLTAGE_POWER_CONTROL_OFS, 32'h00);
    rdchk(POWER_STATUS_OFS, 32'h18);
    finish_test();
  end
endmodule
`default_nettype wire
